/* File: rtl/dcs_channel.sv */
// dma channel: transfer type, address stepping, device steering, data buffering
//
// Behaviour
// R1 - three transfer types, device side uses steering
// R2 - mem-to-mem by soft flag or request, no ack
// R3 - mem-to-mem handled by this one channel
// R4 - serial tx and rx each pick own channel
// R5 - width selects step of four, two, one
// R6 - software aligns addresses to transfer width
// R7 - memory interface splits wide access into beats
// R8 - source used from memory, destination to memory
// R9 - init copies programmed addresses into current pointers
// R10 - pointers independently increment, decrement or hold
// R11 - steering register at individually decoded address
// R12 - disabled steering register ignores requests
// R13 - enabled steering forwards request, returns ack
// R14 - channel acknowledges device request on steering output
// R15 - software enables one steering register per channel
// R16 - device encodes request and status pairs
// R17 - mem-to-mem ignores termination status
// R18 - ack and control encode four outcomes
// R19 - device moves data while ack high
// R20 - termination control idle in mem-to-mem
// R21 - no hardware address protection exists
// R22 - ack lasts one cycle, no waits
// R23 - software request flag self-clears when taken
// R24 - two-bit select picks channel zero to three
// R25 - steering enable clear after reset
// R26 - steering sampled and driven on bus clock
`timescale 1ns/1ps
module dcs_channel
#(
  parameter logic [1:0] CHAN_ID = 2'h0    // this channel's number
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // channel configuration
  input  wire logic [1:0]  xfer_type_in,          // dcs_xfer_t code
  input  wire logic [1:0]  transfer_width_field_in,
  input  wire logic [1:0]  source_step_mode_in,
  input  wire logic [1:0]  dest_step_mode_in,
  input  wire logic [31:0] src_addr_in,
  input  wire logic [31:0] dst_addr_in,
  input  wire logic        init_in,               // channel initialisation pulse
  input  wire logic        software_request_flag_in,
  input  wire logic [1:0]  mem_width_in,          // external memory width
  // serial port steering
  input  wire logic        uart_tx_en_in,
  input  wire logic [1:0]  uart_tx_sel_in,
  input  wire logic        uart_tx_req_in,
  input  wire logic        uart_rx_en_in,
  input  wire logic [1:0]  uart_rx_sel_in,
  input  wire logic        uart_rx_req_in,
  // steering register write
  input  wire logic        steer_wr_in,           // decoded address hit
  input  wire logic [3:0]  steer_wdata_in,
  // user logic device
  input  wire logic        device_transfer_request_in,
  input  wire logic        terminate_status_in,
  input  wire logic [31:0] dev_data_in,
  // memory data
  input  wire logic [31:0] mem_rdata_in,
  input  wire logic        mem_ready_in,          // memory can take a beat
  // outputs
  output logic             device_transfer_ack_out,
  output logic             terminate_control_out,
  output logic [3:0]       steer_cfg_out,
  output logic             soft_taken_out,
  output logic [31:0]      cur_src_out,
  output logic [31:0]      cur_dst_out,
  output logic [31:0]      mem_addr_out,
  output logic             mem_wr_out,
  output logic             mem_rd_out,
  output logic [31:0]      mem_wdata_out,
  output logic [31:0]      dev_wdata_out,
  output logic             done_last_out,
  output logic             retransmit_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_SPLIT} dcs_state_t;

  dcs_state_t  state_ff;
  dcs_state_t  nxt_state;
  logic [31:0] src_ff;
  logic [31:0] nxt_src;
  logic [31:0] dst_ff;
  logic [31:0] nxt_dst;
  logic [31:0] step;
  logic        taken_ff;
  logic        nxt_taken;
  logic        last_ff;
  logic        nxt_last;
  logic        rtx_ff;
  logic        nxt_rtx;
  logic [1:0]  beat_ff;
  logic [1:0]  nxt_beat;
  logic [1:0]  beats;
  logic [31:0] addr_ff;
  logic [31:0] nxt_addr;
  logic        wr_ff;
  logic        nxt_wr;
  logic        rd_ff;
  logic        nxt_rd;
  logic [31:0] dwd_ff;
  logic [31:0] nxt_dwd;
  logic [31:0] mwd_ff;       // write data held with its write strobe
  logic [31:0] nxt_mwd;
  logic        b_pop;        // buffer head consumed on the last beat
  // steering link
  logic        st_req;
  logic        st_stat;
  logic [3:0]  st_cfg;
  logic        st_mine;
  logic        ack_pulse;
  logic        ctl_pulse;
  // request decode
  logic        uart_req;
  logic        req_any;
  logic        is_m2m;
  // buffer
  logic        b_valid;
  logic        b_ready;
  logic [31:0] b_data;
  logic        b_in_valid;
  logic [31:0] b_in_data;

  // steering register; its selected channel gates the returned pulses
  dcs_steer u_steer
  (
    .clk_in                     (clk_in),
    .rst_in                     (rst_in),
    .wr_in                      (steer_wr_in),     // [R11]
    .wdata_in                   (steer_wdata_in),
    .device_transfer_request_in (device_transfer_request_in),
    .terminate_status_in        (terminate_status_in),
    .chan_ack_in                (ack_pulse),
    .chan_ctl_in                (ctl_pulse),
    .cfg_out                    (st_cfg),
    .req_out                    (st_req),
    .stat_out                   (st_stat),
    .device_transfer_ack_out    (device_transfer_ack_out),
    .terminate_control_out      (terminate_control_out)
  );

  // buffer between memory read or device data and the memory write side
  dcs_buf2 u_buf
  (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .s_valid_in  (b_in_valid),
    .s_data_in   (b_in_data),
    .s_ready_out (b_ready),
    .m_valid_out (b_valid),
    .m_data_out  (b_data),
    .m_ready_in  (b_pop)
  );

  // request decode: serial ports and the steering register
  always_comb
  begin
    st_mine  = (st_cfg[dcs_pkg::SEL_HI:dcs_pkg::SEL_LO] == CHAN_ID);            // [R24]
    uart_req = (uart_tx_en_in && uart_tx_sel_in == CHAN_ID && uart_tx_req_in)
             | (uart_rx_en_in && uart_rx_sel_in == CHAN_ID && uart_rx_req_in);  // [R4]
    is_m2m   = (xfer_type_in == dcs_pkg::DCS_M2M);
    req_any  = (st_mine && st_req) || uart_req
             || (st_mine && st_stat && !is_m2m)
             || (is_m2m && software_request_flag_in);                          // [R2] [R3]
  end

  // step size from the transfer width field
  always_comb
  begin
    unique case (transfer_width_field_in)
      dcs_pkg::WIDTH_WORD: step = dcs_pkg::STEP_WORD;                          // [R5]
      dcs_pkg::WIDTH_HALF: step = dcs_pkg::STEP_HALF;
      default:             step = dcs_pkg::STEP_BYTE;
    endcase
    // narrower memory needs more beats per word; a reserved code is handled like half-width memory
    if (mem_width_in == dcs_pkg::MEM_BYTE && transfer_width_field_in == dcs_pkg::WIDTH_WORD)
      beats = 2'h3;
    else if (mem_width_in != dcs_pkg::MEM_WORD && transfer_width_field_in != dcs_pkg::WIDTH_BYTE)
      beats = 2'h1;
    else
      beats = 2'h0;                                                             // [R7]
  end

  // transfer sequencer, pointers and handshake
  always_comb
  begin
    nxt_state = state_ff;
    nxt_src   = src_ff;
    nxt_dst   = dst_ff;
    nxt_taken = 1'b0;
    nxt_last  = 1'b0;
    nxt_rtx   = 1'b0;
    nxt_beat  = beat_ff;
    nxt_addr  = addr_ff;
    nxt_wr    = 1'b0;
    nxt_rd    = 1'b0;
    nxt_dwd   = dwd_ff;
    ack_pulse = 1'b0;
    ctl_pulse = 1'b0;
    b_in_valid = 1'b0;
    b_in_data  = 32'h0;
    nxt_mwd    = mwd_ff;
    b_pop      = 1'b0;
    if (init_in)
    begin
      nxt_src   = src_addr_in;                                                  // [R9]
      nxt_dst   = dst_addr_in;
      nxt_state = ST_IDLE;
    end
    else
    begin
      // device data is only valid while its ack stands
      if (device_transfer_ack_out && xfer_type_in == dcs_pkg::DCS_D2M)
      begin
        b_in_valid = 1'b1;
        b_in_data  = dev_data_in;                                               // [R19]
      end
      unique case (state_ff)
        ST_IDLE:
        begin
          if (req_any && b_ready)
          begin
            nxt_taken = is_m2m && software_request_flag_in;                     // [R23]
            // device outcome codes are meaningless in mem-to-mem
            if (!is_m2m && st_stat && st_mine)                                  // [R16] [R17]
            begin
              ctl_pulse = 1'b1;                                                 // [R18] [R20]
              nxt_last  = st_req;
              nxt_rtx   = !st_req;
            end
            if (!is_m2m && (st_req || !st_stat))
              ack_pulse = st_mine && st_req;                                    // [R14] [R22]
            // source only read from memory, destination only written to memory
            if (xfer_type_in != dcs_pkg::DCS_D2M)                               // [R8]
            begin
              nxt_addr   = src_ff;
              nxt_rd     = 1'b1;
              b_in_valid = is_m2m;
              b_in_data  = mem_rdata_in;
            end
            else if (!ack_pulse)
            begin
              // serial or retransmit: no ack cycle, take the word now
              b_in_valid = 1'b1;
              b_in_data  = dev_data_in;
            end
            if (xfer_type_in == dcs_pkg::DCS_M2D)
              nxt_dwd = mem_rdata_in;
            nxt_beat  = beats;
            nxt_state = (xfer_type_in == dcs_pkg::DCS_M2D) ? ST_IDLE : ST_XFER; // [R1]
            if (xfer_type_in == dcs_pkg::DCS_M2D)
            begin
              // pointer moves right after a memory-to-device transfer
              unique case (source_step_mode_in)
                dcs_pkg::MODE_INC: nxt_src = src_ff + step;                     // [R10]
                dcs_pkg::MODE_DEC: nxt_src = src_ff - step;
                default:           nxt_src = src_ff;
              endcase
            end
          end
        end
        ST_XFER, ST_SPLIT:
        begin
          if (b_valid && mem_ready_in)
          begin
            nxt_addr = dst_ff + {30'h0, beats - beat_ff};
            nxt_wr   = 1'b1;                                                    // [R7]
            nxt_mwd  = b_data;
            if (beat_ff == 2'h0)
            begin
              nxt_state = ST_IDLE;
              b_pop     = 1'b1;
              if (is_m2m)
                unique case (source_step_mode_in)
                  dcs_pkg::MODE_INC: nxt_src = src_ff + step;                   // [R10]
                  dcs_pkg::MODE_DEC: nxt_src = src_ff - step;
                  default:           nxt_src = src_ff;
                endcase
              unique case (dest_step_mode_in)
                dcs_pkg::MODE_INC: nxt_dst = dst_ff + step;                     // [R10]
                dcs_pkg::MODE_DEC: nxt_dst = dst_ff - step;
                default:           nxt_dst = dst_ff;
              endcase
            end
            else
            begin
              nxt_beat  = beat_ff - 2'h1;
              nxt_state = ST_SPLIT;
            end
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      src_ff   <= 32'h0;
      dst_ff   <= 32'h0;
      taken_ff <= 1'b0;
      last_ff  <= 1'b0;
      rtx_ff   <= 1'b0;
      beat_ff  <= 2'h0;
      addr_ff  <= 32'h0;
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
      dwd_ff   <= 32'h0;
      mwd_ff   <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      src_ff   <= nxt_src;
      dst_ff   <= nxt_dst;
      taken_ff <= nxt_taken;
      last_ff  <= nxt_last;
      rtx_ff   <= nxt_rtx;
      beat_ff  <= nxt_beat;
      addr_ff  <= nxt_addr;
      wr_ff    <= nxt_wr;
      rd_ff    <= nxt_rd;
      dwd_ff   <= nxt_dwd;
      mwd_ff   <= nxt_mwd;
    end
  end

  // all outputs straight from flip-flops
  assign steer_cfg_out  = st_cfg;
  assign soft_taken_out = taken_ff;
  assign cur_src_out    = src_ff;
  assign cur_dst_out    = dst_ff;
  assign mem_addr_out   = addr_ff;
  assign mem_wr_out     = wr_ff;
  assign mem_rd_out     = rd_ff;
  assign mem_wdata_out  = mwd_ff;
  assign dev_wdata_out  = dwd_ff;
  assign done_last_out  = last_ff;
  assign retransmit_out = rtx_ff;

  // assertions
  property p_ack_one;
    @(posedge clk_in) disable iff (rst_in) device_transfer_ack_out |=> !device_transfer_ack_out;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle"); // [R22]
  property p_m2m_noack;
    @(posedge clk_in) disable iff (rst_in) is_m2m |-> !ack_pulse && !ctl_pulse;
  endproperty
  a_m2m_noack: assert property (p_m2m_noack) else $error("ack in mem-to-mem"); // [R2]
  property p_init;
    @(posedge clk_in) disable iff (rst_in) init_in |=> cur_src_out == $past(src_addr_in);
  endproperty
  a_init: assert property (p_init) else $error("init did not load source"); // [R9]
  property p_inc;
    @(posedge clk_in) disable iff (rst_in)
      (!init_in && state_ff == ST_IDLE && nxt_state == ST_IDLE && ack_pulse
       && xfer_type_in == dcs_pkg::DCS_M2D && source_step_mode_in == dcs_pkg::MODE_INC)
      |=> cur_src_out == $past(src_ff) + $past(step);
  endproperty
  a_inc: assert property (p_inc) else $error("source not stepped"); // [R10]
  property p_soft;
    @(posedge clk_in) disable iff (rst_in) soft_taken_out |-> $past(is_m2m);
  endproperty
  a_soft: assert property (p_soft) else $error("soft take outside mem-to-mem"); // [R23]
  property p_ack_src;
    @(posedge clk_in) disable iff (rst_in) device_transfer_ack_out |-> $past(st_mine);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack to unselected channel"); // [R24]
  c_ack:   cover property (@(posedge clk_in) device_transfer_ack_out);
  c_split: cover property (@(posedge clk_in) state_ff == ST_SPLIT);
  c_rtx:   cover property (@(posedge clk_in) retransmit_out);
endmodule

/* File: rtl/dcs_pkg.sv */
// shared constants and types for the dma channel address and steering block
package dcs_pkg;
  // transfer types
  typedef enum logic [1:0] {DCS_M2M, DCS_M2D, DCS_D2M} dcs_xfer_t;
  // transfer width field encodings
  localparam logic [1:0] WIDTH_WORD = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_BYTE = 2'h2;
  // pointer step sizes per width
  localparam logic [31:0] STEP_WORD = 32'h4;
  localparam logic [31:0] STEP_HALF = 32'h2;
  localparam logic [31:0] STEP_BYTE = 32'h1;
  // step mode encodings
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_INC  = 2'h1;
  localparam logic [1:0] MODE_DEC  = 2'h2;
  // steering register field layout and reset value
  localparam int          SEL_LO       = 1;
  localparam int          SEL_HI       = 2;
  localparam int          EN_POS       = 0;
  localparam logic [3:0]  STEER_RESET  = 4'h0;
  localparam int          NUM_CHANNELS = 4;
  // memory bus width selector (codes 0, 1, 2 for 1, 2 or 4 bytes per beat)
  localparam logic [1:0] MEM_BYTE = 2'h0;
  localparam logic [1:0] MEM_HALF = 2'h1;
  localparam logic [1:0] MEM_WORD = 2'h2;
endpackage

/* File: rtl/dcs_steer.sv */
// one steering register between a user logic device and a dma channel
`timescale 1ns/1ps
module dcs_steer
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // register write port
  input  wire logic       wr_in,
  input  wire logic [3:0] wdata_in,
  // device side
  input  wire logic       device_transfer_request_in,
  input  wire logic       terminate_status_in,
  // channel side
  input  wire logic       chan_ack_in,
  input  wire logic       chan_ctl_in,
  // outputs
  output logic [3:0]      cfg_out,
  output logic            req_out,
  output logic            stat_out,
  output logic            device_transfer_ack_out,
  output logic            terminate_control_out
);
  logic [3:0] cfg_ff;
  logic [3:0] nxt_cfg;
  logic       req_ff;
  logic       nxt_req;
  logic       stat_ff;
  logic       nxt_stat;
  logic       ack_ff;
  logic       nxt_ack;
  logic       ctl_ff;
  logic       nxt_ctl;
  logic       en;

  assign en = cfg_ff[dcs_pkg::EN_POS];

  // sample request/status, return ack/control, all on the bus clock
  always_comb
  begin
    nxt_cfg  = wr_in ? wdata_in : cfg_ff;
    nxt_req  = en & device_transfer_request_in;   // [R12] [R13] [R26]
    nxt_stat = en & terminate_status_in;          // [R13]
    nxt_ack  = en & chan_ack_in;                  // [R13] [R14]
    nxt_ctl  = en & chan_ctl_in;                  // [R13]
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cfg_ff  <= dcs_pkg::STEER_RESET;            // [R25]
      req_ff  <= 1'b0;
      stat_ff <= 1'b0;
      ack_ff  <= 1'b0;
      ctl_ff  <= 1'b0;
    end
    else
    begin
      cfg_ff  <= nxt_cfg;
      req_ff  <= nxt_req;
      stat_ff <= nxt_stat;
      ack_ff  <= nxt_ack;
      ctl_ff  <= nxt_ctl;
    end
  end

  assign cfg_out                 = cfg_ff;
  assign req_out                 = req_ff;
  assign stat_out                = stat_ff;
  assign device_transfer_ack_out = ack_ff;
  assign terminate_control_out   = ctl_ff;

  // assertions
  property p_dis_ignore;
    @(posedge clk_in) disable iff (rst_in) !en |=> !req_ff;
  endproperty
  a_dis_ignore: assert property (p_dis_ignore) else $error("request forwarded while disabled"); // [R12]
  property p_fwd;
    @(posedge clk_in) disable iff (rst_in) (en && device_transfer_request_in) |=> req_ff;
  endproperty
  a_fwd: assert property (p_fwd) else $error("request not forwarded"); // [R13]
endmodule

/* File: rtl/dcs_buf2.sv */
// two-entry valid/ready buffer in the data path
`timescale 1ns/1ps
module dcs_buf2
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // fill side
  input  wire logic        s_valid_in,
  input  wire logic [31:0] s_data_in,
  output logic             s_ready_out,
  // drain side
  output logic             m_valid_out,
  output logic [31:0]      m_data_out,
  input  wire logic        m_ready_in
);
  logic [31:0] mem_ff [2];
  logic [31:0] nxt_mem [2];
  logic        rp_ff;
  logic        nxt_rp;
  logic        wp_ff;
  logic        nxt_wp;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  logic        push;
  logic        pop;

  // pointer and count update; full and empty come from the count
  always_comb
  begin
    push    = s_valid_in && (cnt_ff != 2'h2);
    pop     = m_ready_in && (cnt_ff != 2'h0);
    nxt_mem = mem_ff;
    if (push)
      nxt_mem[wp_ff] = s_data_in;
    nxt_wp  = push ? ~wp_ff : wp_ff;
    nxt_rp  = pop ? ~rp_ff : rp_ff;
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rp_ff  <= 1'b0;
      wp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      rp_ff  <= nxt_rp;
      wp_ff  <= nxt_wp;
      cnt_ff <= nxt_cnt;
    end
    mem_ff <= nxt_mem;
  end

  assign s_ready_out = (cnt_ff != 2'h2);
  assign m_valid_out = (cnt_ff != 2'h0);
  assign m_data_out  = mem_ff[rp_ff];
endmodule

/* File: bench/dcs_dev_model.sv */
// user logic device model on the far side of the steering register
`timescale 1ns/1ps
module dcs_dev_model
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // bench control: one-cycle go, code is {status, request}
  input  wire logic        go_in,
  input  wire logic [1:0]  code_in,
  // steering side
  input  wire logic        ack_in,
  input  wire logic [31:0] dev_wdata_in,
  output logic             req_out,
  output logic             stat_out,
  output logic [31:0]      data_out,
  output logic [31:0]      got_out
);
  logic [31:0] word_ff;  // next word this device presents

  // request and status pair, both low between requests
  assign req_out  = go_in & code_in[0];
  assign stat_out = go_in & code_in[1];
  // data valid only while ack is high; inverted otherwise so stale data never matches
  assign data_out = ack_in ? word_ff : ~word_ff;

  // capture written data on ack and advance the pattern
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      word_ff <= 32'ha5c3_0001;
      got_out <= 32'h0;
    end
    else if (ack_in)
    begin
      word_ff <= word_ff + 32'h1;
      got_out <= dev_wdata_in;
    end
  end
endmodule

/* File: bench/test_dcs_channel.sv */
// self-checking bench for the dma channel steering block
`timescale 1ns/1ps
module test_dcs_channel;
  // drives
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  xt = 2'h0, wd = 2'h0, sm = 2'h0, dm = 2'h0, mw = 2'h2;
  // word aligned, and any address is reachable
  logic [31:0] sa = 32'h200, da = 32'h100, mrd = 32'h1234_5678;
  logic        ini = 1'b0, sw = 1'b0, swr = 1'b0, go = 1'b0, mrdy = 1'b1;
  logic [1:0]  code = 2'h0, txs = 2'h0, rxs = 2'h0;
  logic        txe = 1'b0, txr = 1'b0, rxe = 1'b0, rxr = 1'b0;
  logic [3:0]  swd = 4'h0;
  // observed
  logic        rq, st, ack, ctl, stk, mwr, mrdo, dl, rt, ack_q;
  logic [3:0]  cfg;
  logic [31:0] dd, got, cs, cd, ma, mwd, dwd, cap, lw;
  int          n_fail = 0, n_checks = 0, cyc = 0, i, k;
  int          na, nc, nr, ns, nd, nt, dbl;
  logic [31:0] wq[$];  // write beat addresses

  always #50 clk_in = ~clk_in;

  dcs_channel dut_u (.clk_in(clk_in), .rst_in(rst_in), .xfer_type_in(xt),
    .transfer_width_field_in(wd), .source_step_mode_in(sm), .dest_step_mode_in(dm),
    .src_addr_in(sa), .dst_addr_in(da), .init_in(ini), .software_request_flag_in(sw),
    .mem_width_in(mw), .uart_tx_en_in(txe), .uart_tx_sel_in(txs), .uart_tx_req_in(txr),
    .uart_rx_en_in(rxe), .uart_rx_sel_in(rxs), .uart_rx_req_in(rxr),
    .steer_wr_in(swr), .steer_wdata_in(swd), .device_transfer_request_in(rq),
    .terminate_status_in(st), .dev_data_in(dd), .mem_rdata_in(mrd),
    .mem_ready_in(mrdy), .device_transfer_ack_out(ack), .terminate_control_out(ctl),
    .steer_cfg_out(cfg), .soft_taken_out(stk), .cur_src_out(cs), .cur_dst_out(cd),
    .mem_addr_out(ma), .mem_wr_out(mwr), .mem_rd_out(mrdo), .mem_wdata_out(mwd),
    .dev_wdata_out(dwd), .done_last_out(dl), .retransmit_out(rt));

  dcs_dev_model dev_u (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .code_in(code),
    .ack_in(ack), .dev_wdata_in(dwd), .req_out(rq), .stat_out(st), .data_out(dd),
    .got_out(got));

  // monitor: counts pulses at each edge, before the edge's own updates land
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (!rst_in)
    begin
      if (ack) na++;
      if (ack && ack_q) dbl++;
      if (ack) cap = dd;
      if (ctl) nc++;
      if (mwr) wq.push_back(ma);
      if (mwr) lw = mwd;
      if (mrdo) nr++;
      if (stk) ns++;
      if (dl) nd++;
      if (rt) nt++;
    end
    ack_q = ack;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize();
    end
  end

  task chk(input bit c, input string m);
    n_checks++;
    if (!c)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // expected pointer after one transfer
  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] w,
                                       input logic [1:0] m);
    logic [31:0] s;
    s = (w == dcs_pkg::WIDTH_WORD) ? dcs_pkg::STEP_WORD :
        (w == dcs_pkg::WIDTH_HALF) ? dcs_pkg::STEP_HALF : dcs_pkg::STEP_BYTE;
    return (m == dcs_pkg::MODE_INC) ? a + s : (m == dcs_pkg::MODE_DEC) ? a - s : a;
  endfunction

  // configure, pulse init, clear the monitor
  task setup(input logic [1:0] t, w, s, d);
    @(negedge clk_in);
    {xt, wd, sm, dm, ini} = {t, w, s, d, 1'b1};
    @(negedge clk_in);
    ini = 1'b0;
    {na, nc, nr, ns, nd, nt, dbl} = '0;
    wq.delete();
  endtask

  // one-cycle device request, then let the transfer finish
  task req(input logic [1:0] c);
    @(negedge clk_in);
    {go, code} = {1'b1, c};
    @(negedge clk_in);
    go = 1'b0;
    repeat (16) @(negedge clk_in);
  endtask

  task steer(input logic [3:0] v);
    @(negedge clk_in);
    {swr, swd} = {1'b1, v};
    @(negedge clk_in);
    swr = 1'b0;
  endtask

  task summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(cfg === 4'h0 && ack === 1'b0 && cd === 32'h0, "reset values");
    setup(dcs_pkg::DCS_D2M, 2'h0, 2'h0, 2'h1);
    req(2'h1);
    chk(na == 0 && wq.size() == 0, "disabled steering answered");
    steer(4'h3);
    req(2'h1);
    chk(cfg === 4'h3 && na == 0, "other channel answered");
    steer(4'h1);
    chk(cfg === 4'h1, "steering value");
    // every width with every step mode, both device directions
    for (i = 0; i < 9; i++)
    begin
      setup(dcs_pkg::DCS_D2M, i / 3, 2'h0, i % 3);
      req(2'h1);
      chk(cd === step(da, i / 3, i % 3) && na == 1 && dbl == 0, "d2m step");
      chk(wq.size() == 1 && wq[0] === da && lw === cap, "d2m data");
      setup(dcs_pkg::DCS_M2D, i / 3, i % 3, 2'h1);
      req(2'h1);
      chk(cs === step(sa, i / 3, i % 3) && cd === da, "m2d step");
      chk(na == 1 && nr >= 1 && got === mrd, "m2d data");
    end
    // last request and retransmit
    setup(dcs_pkg::DCS_D2M, 2'h0, 2'h0, 2'h1);
    req(2'h3);
    chk(na == 1 && nc == 1 && nd == 1, "last acknowledge");
    req(2'h2);
    chk(na == 1 && nc == 2 && nt == 1, "retransmit acknowledge");
    // mem-to-mem by request with status: no ack, no control, both pointers step
    setup(dcs_pkg::DCS_M2M, 2'h0, 2'h1, 2'h2);
    req(2'h3);
    chk(na == 0 && nc == 0 && wq.size() >= 1, "m2m by request");
    chk(cs === sa + 32'h4 && cd === da - 32'h4, "m2m pointers");
    // mem-to-mem by software flag, cleared once taken
    setup(dcs_pkg::DCS_M2M, 2'h1, 2'h1, 2'h1);
    sw = 1'b1;
    for (k = 0; k < 20 && ns == 0; k++) @(negedge clk_in);
    sw = 1'b0;
    repeat (16) @(negedge clk_in);
    chk(ns == 1 && na == 0 && cd === da + 32'h2, "soft request");
    // word into byte memory with the memory stalled first
    mw = dcs_pkg::MEM_BYTE;
    mrdy = 1'b0;
    setup(dcs_pkg::DCS_D2M, 2'h0, 2'h0, 2'h1);
    req(2'h1);
    mrdy = 1'b1;
    repeat (16) @(negedge clk_in);
    chk(wq.size() == 4 && wq[0] === da && wq[3] === da + 32'h3, "byte beats");
    mw = dcs_pkg::MEM_WORD;
    // serial receiver and transmitter steered to this channel or away
    rxe = 1'b1;
    txe = 1'b1;
    setup(dcs_pkg::DCS_D2M, 2'h0, 2'h0, 2'h1);
    rxr = 1'b1;
    @(negedge clk_in);
    rxr = 1'b0;
    repeat (16) @(negedge clk_in);
    chk(wq.size() == 1, "receiver serviced");
    rxs = 2'h1;
    setup(dcs_pkg::DCS_M2D, 2'h0, 2'h1, 2'h0);
    {rxr, txr} = 2'h3;
    @(negedge clk_in);
    {rxr, txr} = 2'h0;
    repeat (16) @(negedge clk_in);
    chk(nr >= 1 && wq.size() == 0, "transmitter serviced");
    summarize();
  end
endmodule
